// File: core/link_fmt_pkg.sv
package link_fmt_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] REG_CTRL     = 5'h00;
  localparam logic [4:0] REG_STATUS   = 5'h04;
  localparam logic [4:0] REG_RX_LEVEL = 5'h08;
  localparam logic [4:0] REG_RX_DATA  = 5'h0C;
  localparam logic [4:0] REG_TX_DATA  = 5'h10;
  localparam logic [4:0] REG_TX_SPACE = 5'h14;

  // Control bits and their value after reset.
  localparam int         CTRL_RX_EN = 0;
  localparam int         CTRL_TX_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Sticky status bits, write one to clear.
  localparam int         ST_PRIO    = 0;
  localparam int         ST_ALIGN   = 1;
  localparam int         ST_SPEED   = 2;
  localparam int         ST_OVFL    = 3;
  localparam int         ST_TAG     = 4;
  localparam logic [4:0] STAT_RESET = 5'h00;

  typedef enum logic [1:0] {
    RT_NEW     = 2'b00,
    RT_RETRY_X = 2'b01,
    RT_RETRY_A = 2'b10,
    RT_RETRY_B = 2'b11
  } retry_t;

  typedef enum logic [1:0] {
    SPD_100   = 2'b00,
    SPD_200   = 2'b01,
    SPD_400   = 2'b10,
    SPD_UNDEF = 2'b11
  } speed_t;

  localparam logic [1:0] ISO_TAG_FORMATTED = 2'h0;
  localparam logic [3:0] TCODE_WR_RESP     = 4'h2;
  localparam logic [3:0] TCODE_LOCK_RESP   = 4'hB;
  localparam logic [2:0] RX_HDR_QUADS      = 3'h4;

  // Field positions in the receive status quadlet and the transmit header.
  localparam int STAT_SPD_LSB = 16;
  localparam int ISO_LEN_LSB  = 16;
  localparam int ISO_TAG_LSB  = 14;
  localparam int ISO_CHAN_LSB = 8;
  localparam int ISO_SPD_LSB  = 4;
  localparam int ISO_SY_LSB   = 0;

  // Whole quadlets needed to hold a byte count.
  function automatic logic [14:0] quads_for_len(input logic [15:0] len);
    logic [16:0] sum;
    sum = {1'b0, len} + 17'h00003;
    return sum[16:2];
  endfunction

endpackage

// File: core/link_fmt_if.sv
`timescale 1ns/1ps

// Write and registered read port of a quadlet memory.
interface quad_mem_if #(parameter int AW = 6);
  logic          we;
  logic [AW-1:0] waddr;
  logic [31:0]   wdata;
  logic [AW-1:0] raddr;
  logic [31:0]   rdata;
  modport mem  (input we, waddr, wdata, raddr, output rdata);
  modport user (output we, waddr, wdata, raddr, input rdata);
endinterface

// One-cycle quadlet strobe with its data.
interface quad_out_if;
  logic        valid;
  logic [31:0] data;
  modport src (output valid, data);
  modport dst (input valid, data);
endinterface

// File: core/quad_mem.sv
`timescale 1ns/1ps

module quad_mem #(
  parameter int AW = 6
) (
  input wire logic clock_i,
  quad_mem_if.mem  port
);

  logic [31:0] store [2**AW];

  // Write on strobe; read data always come out of a register.
  always_ff @(posedge clock_i) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
    port.rdata <= store[port.raddr];
  end

endmodule

// File: core/byte_packer.sv
`timescale 1ns/1ps

module byte_packer (
  input wire logic       clock_i,
  input wire logic       reset_i,
  input wire logic       clear_i,
  input wire logic       byte_valid_i,
  input wire logic [7:0] byte_i,
  input wire logic       flush_i,
  quad_out_if.src        out
);

  logic [23:0] acc;
  logic [1:0]  cnt;

  // First byte lands in the top lane; a short tail is zero padded.
  always_ff @(posedge clock_i) begin
    if (reset_i || clear_i) begin
      acc       <= 24'h000000;
      cnt       <= 2'h0;
      out.valid <= 1'b0;
      out.data  <= 32'h00000000;
    end else begin
      out.valid <= 1'b0;
      if (byte_valid_i) begin
        acc <= {acc[15:0], byte_i};
        cnt <= cnt + 2'h1;
        if (cnt == 2'h3) begin
          out.valid <= 1'b1;
          out.data  <= {acc, byte_i};
        end
      end else if (flush_i && cnt != 2'h0) begin
        out.valid <= 1'b1;
        cnt       <= 2'h0;
        case (cnt)
          2'h1:    out.data <= {acc[7:0], 24'h000000};
          2'h2:    out.data <= {acc[15:0], 16'h0000};
          default: out.data <= {acc, 8'h00};
        endcase
      end
    end
  end

  chk_tail_pad_two: assert property (@(posedge clock_i) disable iff (reset_i)
    (flush_i && !byte_valid_i && !clear_i && cnt == 2'h2) |=> (out.valid && out.data[15:0] == 16'h0000))
    else $error("Two-byte tail not zero padded.");

endmodule

// File: core/serial_link_framer.sv
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ps

// Summary of operation
// - Destination ID is bus then node number.
// - Transaction label passed unchanged for response matching.
// - Retry code new, retry_X, retryA, retryB.
// - Priority bits must be zero on cable.
// - Offset is 48 bits, quadlet aligned.
// - Lock response: rcode on top, rest reserved.
// - Data length counts block bytes; write response unused.
// - First byte in top lane, tail zero padded.
// - Speed codes 100, 200, 400; 11 undefined.
// - Status records the returned acknowledge code.
// - Extended transaction code carried in header.
// - Send all waiting iso packets after cycle start.
// - Iso tag must be zero, others reserved.
// - Send with header speed, length, channel, sync.
// - Header, data quadlets, then one status quadlet.
module serial_link_framer import link_fmt_pkg::*; #(
  parameter int RX_AW = 6,
  parameter int TX_AW = 6
) (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        rx_start_i,
  input  wire logic [9:0]  rx_dest_bus_i,
  input  wire logic [5:0]  rx_dest_node_i,
  input  wire logic [5:0]  rx_label_i,
  input  wire logic [1:0]  rx_retry_i,
  input  wire logic [3:0]  rx_tcode_i,
  input  wire logic [3:0]  rx_priority_i,
  input  wire logic [15:0] rx_source_id_i,
  input  wire logic [47:0] rx_offset_i,
  input  wire logic [15:0] rx_length_i,
  input  wire logic [15:0] rx_ext_tcode_i,
  input  wire logic [1:0]  rx_speed_i,
  input  wire logic        rx_byte_valid_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_end_i,
  input  wire logic [3:0]  returned_ack_code_i,
  input  wire logic        cycle_start_i,
  input  wire logic        iso_ready_i,
  output logic             iso_valid_o,
  output logic             iso_first_o,
  output logic             iso_last_o,
  output logic      [31:0] iso_quad_o,
  output logic      [1:0]  iso_speed_o,
  output logic      [5:0]  iso_chan_o,
  output logic      [3:0]  iso_sy_o,
  output logic      [15:0] iso_len_o
);

  if (RX_AW < 3 || RX_AW > 12 || TX_AW < 3 || TX_AW > 12) begin : g_bad_depth
    $error("Buffer address width must lie between 3 and 12.");
  end

  typedef enum logic [1:0] {
    T_IDLE  = 2'b00,
    T_FETCH = 2'b01,
    T_SEND  = 2'b10,
    T_PAYF  = 2'b11
  } tx_state_t;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  quad_mem_if #(.AW(RX_AW)) rx_mem ();
  quad_mem_if #(.AW(TX_AW)) tx_mem ();
  quad_out_if               pk ();

  logic [1:0]    ctrl;
  logic [4:0]    status;
  logic [4:0]    stat_set;
  logic [4:0]    stat_clr;
  logic [1:0]    rd_stage;
  logic          acc_wr;
  logic          wr_block;
  logic [31:0]   next_readdata;
  logic [31:0]   hdr_q [4];
  logic [2:0]    hdr_idx;
  logic [1:0]    cap_speed;
  logic [31:0]   stat_q;
  logic          stat_pend;
  logic          pend_v;
  logic [31:0]   pend_d;
  logic          rx_drop;
  logic          in_pkt;
  logic          rx_want;
  logic          rx_is_stat;
  logic [RX_AW:0] rx_wptr_work;
  logic [RX_AW:0] rx_wptr_commit;
  logic [RX_AW:0] rx_rptr;
  logic [RX_AW:0] rx_used;
  logic [RX_AW:0] rx_avail;
  logic          rx_full;
  logic [TX_AW:0] tx_wptr;
  logic [TX_AW:0] tx_rptr;
  logic [TX_AW:0] tx_level;
  logic          tx_full;
  logic          tx_go;
  tx_state_t     tx_state;
  logic [14:0]   tx_left;
  logic [14:0]   hdr_need;
  logic          hdr_fits;
  logic [14:0]   chk_beats;

  quad_mem #(.AW(RX_AW)) u_rx_mem (.clock_i(clock_i), .port(rx_mem.mem));
  quad_mem #(.AW(TX_AW)) u_tx_mem (.clock_i(clock_i), .port(tx_mem.mem));

  byte_packer u_packer (
    .clock_i      (clock_i),
    .reset_i      (reset_i),
    .clear_i      (rx_start_i),
    .byte_valid_i (rx_byte_valid_i && in_pkt),
    .byte_i       (rx_byte_i),
    .flush_i      (rx_end_i && in_pkt),
    .out          (pk.src)
  );

  // Fill levels of the two quadlet buffers.
  assign rx_used  = rx_wptr_work - rx_rptr;
  assign rx_full  = rx_used[RX_AW];
  assign rx_avail = rx_wptr_commit - rx_rptr;
  assign tx_level = tx_wptr - tx_rptr;
  assign tx_full  = tx_level[TX_AW];

  // Bus handshake: reads take two wait cycles, a write to a full transmit buffer waits.
  assign wr_block          = (avs_address_i == REG_TX_DATA) && tx_full;
  assign avs_waitrequest_o = (avs_read_i && rd_stage != 2'h2) || (avs_write_i && wr_block);
  assign acc_wr            = avs_write_i && !wr_block;

  // Register read multiplexer; unmapped offsets read zero.
  always_comb begin
    next_readdata = 32'h00000000;
    case (avs_address_i)
      REG_CTRL:     next_readdata = {30'h00000000, ctrl};
      REG_STATUS:   next_readdata = {27'h0000000, status};
      REG_RX_LEVEL: next_readdata = 32'(rx_avail);
      REG_RX_DATA:  next_readdata = (rx_avail != '0) ? rx_mem.rdata : 32'h00000000;
      REG_TX_SPACE: next_readdata = 32'(2 ** TX_AW) - 32'(tx_level);
      default:      next_readdata = 32'h00000000;
    endcase
  end

  // Read sequencing; a receive data read pops one quadlet.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rd_stage       <= 2'h0;
      avs_readdata_o <= 32'h00000000;
      rx_rptr        <= '0;
    end else if (avs_read_i) begin
      case (rd_stage)
        2'h0: rd_stage <= 2'h1;
        2'h1: begin
          rd_stage       <= 2'h2;
          avs_readdata_o <= next_readdata;
          if (avs_address_i == REG_RX_DATA && rx_avail != '0) begin
            rx_rptr <= rx_rptr + 1'b1;
          end
        end
        default: rd_stage <= 2'h0;
      endcase
    end else begin
      rd_stage <= 2'h0;
    end
  end

  // Control register write.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ctrl <= CTRL_RESET;
    end else if (acc_wr && avs_address_i == REG_CTRL && avs_byteenable_i[0]) begin
      ctrl <= avs_writedata_i[1:0];
    end
  end

  // Status flags: a new event wins over a clear in the same cycle.
  assign stat_clr = (acc_wr && avs_address_i == REG_STATUS && avs_byteenable_i[0]) ? avs_writedata_i[4:0] : 5'h00;
  always_comb begin
    stat_set = 5'h00;
    if (rx_start_i && ctrl[CTRL_RX_EN]) begin
      stat_set[ST_PRIO]  = (rx_priority_i != 4'h0);
      stat_set[ST_ALIGN] = (rx_offset_i[1:0] != 2'h0);
      stat_set[ST_SPEED] = (rx_speed_i == SPD_UNDEF);
    end
    stat_set[ST_OVFL] = rx_want && rx_full && !rx_drop;
    stat_set[ST_TAG]  = (tx_state == T_FETCH) && hdr_fits &&
                        (tx_mem.rdata[ISO_TAG_LSB +: 2] != ISO_TAG_FORMATTED);
  end
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      status <= STAT_RESET;
    end else begin
      status <= (status & ~stat_clr) | stat_set;
    end
  end

  // Receive header capture; destination, label, retry and codes pass as received.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      hdr_q     <= '{default: 32'h00000000};
      cap_speed <= SPD_100;
      stat_q    <= 32'h00000000;
    end else begin
      if (rx_start_i && ctrl[CTRL_RX_EN]) begin
        hdr_q[0]  <= {rx_dest_bus_i, rx_dest_node_i, rx_label_i,
                      rx_retry_i, rx_tcode_i, rx_priority_i};
        hdr_q[1]  <= {rx_source_id_i, (rx_tcode_i == TCODE_LOCK_RESP) ?
                      {rx_offset_i[47:44], 12'h000} : rx_offset_i[47:32]};
        hdr_q[2]  <= rx_offset_i[31:0];
        hdr_q[3]  <= {(rx_tcode_i == TCODE_WR_RESP) ? 16'h0000 : rx_length_i, rx_ext_tcode_i};
        cap_speed <= rx_speed_i;
      end
      if (rx_end_i && in_pkt) begin
        stat_q <= {14'h0000, cap_speed, 12'h000, returned_ack_code_i};
      end
    end
  end

  // Receive write selection: header, then data, then the status quadlet.
  always_comb begin
    rx_want    = 1'b0;
    rx_is_stat = 1'b0;
    rx_mem.wdata = 32'h00000000;
    if (hdr_idx < RX_HDR_QUADS) begin
      rx_want      = 1'b1;
      rx_mem.wdata = hdr_q[hdr_idx[1:0]];
    end else if (pend_v) begin
      rx_want      = 1'b1;
      rx_mem.wdata = pend_d;
    end else if (stat_pend && !pk.valid) begin
      rx_want      = 1'b1;
      rx_is_stat   = 1'b1;
      rx_mem.wdata = stat_q;
    end
  end
  assign rx_mem.we    = rx_want && !rx_drop && !rx_full;
  assign rx_mem.waddr = rx_wptr_work[RX_AW-1:0];
  assign rx_mem.raddr = rx_rptr[RX_AW-1:0];

  // Receive packet sequencing; software only sees whole packets.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      hdr_idx        <= RX_HDR_QUADS;
      in_pkt         <= 1'b0;
      stat_pend      <= 1'b0;
      pend_v         <= 1'b0;
      pend_d         <= 32'h00000000;
      rx_drop        <= 1'b0;
      rx_wptr_work   <= '0;
      rx_wptr_commit <= '0;
    end else if (rx_start_i && ctrl[CTRL_RX_EN]) begin
      hdr_idx      <= 3'h0;
      in_pkt       <= 1'b1;
      stat_pend    <= 1'b0;
      pend_v       <= 1'b0;
      rx_drop      <= 1'b0;
      rx_wptr_work <= rx_wptr_commit;
    end else begin
      if (rx_end_i && in_pkt) begin
        in_pkt    <= 1'b0;
        stat_pend <= 1'b1;
      end
      if (rx_want) begin
        if (rx_full) begin
          rx_drop <= 1'b1;
        end else if (!rx_drop) begin
          rx_wptr_work <= rx_wptr_work + 1'b1;
        end
        if (hdr_idx < RX_HDR_QUADS) begin
          hdr_idx <= hdr_idx + 3'h1;
        end else if (pend_v) begin
          pend_v <= 1'b0;
        end
      end
      if (pk.valid) begin
        pend_v <= 1'b1;
        pend_d <= pk.data;
      end
      if (rx_is_stat) begin
        stat_pend <= 1'b0;
        if (rx_drop || rx_full) begin
          rx_wptr_work <= rx_wptr_commit;
        end else begin
          rx_wptr_commit <= rx_wptr_work + 1'b1;
        end
      end
    end
  end

  // Transmit buffer fill from the bus; the host keeps send order.
  assign tx_mem.we    = acc_wr && avs_address_i == REG_TX_DATA;
  assign tx_mem.waddr = tx_wptr[TX_AW-1:0];
  assign tx_mem.wdata = avs_writedata_i;
  assign tx_mem.raddr = tx_rptr[TX_AW-1:0];

  // Header decode while the head quadlet is on the read port.
  assign hdr_need = quads_for_len(tx_mem.rdata[ISO_LEN_LSB +: 16]);
  assign hdr_fits = (17'(tx_level) > {2'h0, hdr_need});

  // Cycle start arms the sender until the buffer holds no whole packet.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tx_go <= 1'b0;
    end else if (cycle_start_i && ctrl[CTRL_TX_EN]) begin
      tx_go <= 1'b1;
    end else if ((tx_state == T_IDLE && tx_level == '0) || (tx_state == T_FETCH && !hdr_fits)) begin
      tx_go <= 1'b0;
    end
  end

  // Isochronous sender: header beat, then the rounded-up payload beats.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tx_state    <= T_IDLE;
      tx_wptr     <= '0;
      tx_rptr     <= '0;
      tx_left     <= 15'h0000;
      iso_valid_o <= 1'b0;
      iso_first_o <= 1'b0;
      iso_last_o  <= 1'b0;
      iso_quad_o  <= 32'h00000000;
      iso_speed_o <= SPD_100;
      iso_chan_o  <= 6'h00;
      iso_sy_o    <= 4'h0;
      iso_len_o   <= 16'h0000;
    end else begin
      if (tx_mem.we) begin
        tx_wptr <= tx_wptr + 1'b1;
      end
      case (tx_state)
        T_IDLE: begin
          if (tx_go && tx_level != '0 && ctrl[CTRL_TX_EN]) begin
            tx_state <= T_FETCH;
          end
        end
        T_FETCH: begin
          if (!hdr_fits) begin
            tx_state <= T_IDLE;
          end else if (tx_mem.rdata[ISO_TAG_LSB +: 2] != ISO_TAG_FORMATTED) begin
            tx_rptr  <= tx_rptr + (TX_AW + 1)'(hdr_need) + 1'b1;
            tx_state <= T_IDLE;
          end else begin
            iso_quad_o  <= tx_mem.rdata;
            iso_len_o   <= tx_mem.rdata[ISO_LEN_LSB +: 16];
            iso_chan_o  <= tx_mem.rdata[ISO_CHAN_LSB +: 6];
            iso_speed_o <= tx_mem.rdata[ISO_SPD_LSB +: 2];
            iso_sy_o    <= tx_mem.rdata[ISO_SY_LSB +: 4];
            iso_valid_o <= 1'b1;
            iso_first_o <= 1'b1;
            iso_last_o  <= (hdr_need == 15'h0000);
            tx_left     <= hdr_need;
            tx_rptr     <= tx_rptr + 1'b1;
            tx_state    <= T_SEND;
          end
        end
        T_SEND: begin
          if (iso_ready_i) begin
            iso_valid_o <= 1'b0;
            tx_state    <= (tx_left == 15'h0000) ? T_IDLE : T_PAYF;
          end
        end
        T_PAYF: begin
          iso_quad_o  <= tx_mem.rdata;
          iso_valid_o <= 1'b1;
          iso_first_o <= 1'b0;
          iso_last_o  <= (tx_left == 15'h0001);
          tx_left     <= tx_left - 15'h0001;
          tx_rptr     <= tx_rptr + 1'b1;
          tx_state    <= T_SEND;
        end
        default: tx_state <= T_IDLE;
      endcase
    end
  end

  // Payload beats handed over since the header beat.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      chk_beats <= 15'h0000;
    end else if (iso_valid_o && iso_ready_i) begin
      chk_beats <= iso_first_o ? 15'h0000 : chk_beats + 15'h0001;
    end
  end

  chk_dest_id_pack: assert property (rx_mem.we && hdr_idx == 3'h0 |->
    rx_mem.wdata[31:16] == {$past(rx_dest_bus_i), $past(rx_dest_node_i)})
    else $error("Destination ID lane wrong.");
  chk_header_order: assert property ((rx_start_i && ctrl[CTRL_RX_EN]) ##1 (!rx_start_i && !rx_full)[*4] |=>
    hdr_idx == RX_HDR_QUADS)
    else $error("Header quadlets not written in four cycles.");
  chk_lock_reserved: assert property (rx_mem.we && hdr_idx == 3'h1 && hdr_q[0][7:4] == TCODE_LOCK_RESP |->
    rx_mem.wdata[11:0] == 12'h000)
    else $error("Lock response reserved bits not zero.");
  chk_wresp_length: assert property (rx_mem.we && hdr_idx == 3'h3 && hdr_q[0][7:4] == TCODE_WR_RESP |->
    rx_mem.wdata[31:16] == 16'h0000)
    else $error("Write response length not zero.");
  chk_status_commit: assert property (rx_mem.we && rx_is_stat && !rx_start_i |=>
    rx_wptr_commit == $past(rx_wptr_work) + 1'b1)
    else $error("Status quadlet did not publish packet.");
  chk_ack_capture: assert property (rx_end_i && in_pkt |=>
    stat_q[3:0] == $past(returned_ack_code_i))
    else $error("Returned acknowledge not recorded.");
  chk_prio_flag: assert property (rx_start_i && ctrl[CTRL_RX_EN] && rx_priority_i != 4'h0 |=> status[ST_PRIO])
    else $error("Nonzero priority not flagged.");
  chk_cycle_start: assert property (cycle_start_i && ctrl[CTRL_TX_EN] && tx_state == T_IDLE && tx_level != '0 |->
    ##[1:2] tx_state == T_FETCH)
    else $error("Cycle start did not begin sending.");
  chk_iso_beats: assert property (iso_valid_o && iso_last_o && !iso_first_o |->
    chk_beats + 15'h0001 == quads_for_len(iso_len_o))
    else $error("Payload beat count differs from length.");
  chk_iso_tag_zero: assert property (iso_valid_o && iso_first_o |->
    iso_quad_o[ISO_TAG_LSB +: 2] == ISO_TAG_FORMATTED)
    else $error("Reserved tag sent.");
  chk_iso_hold: assert property (iso_valid_o && !iso_ready_i |=>
    iso_valid_o && $stable(iso_quad_o) && $stable(iso_speed_o) && $stable(iso_chan_o))
    else $error("Beat changed while stalled.");

endmodule

// File: tb/iso_sink.sv
`timescale 1ns/1ps

// Link-side sink for isochronous beats; it stalls at random so every beat must hold.
module iso_sink (
  input  wire logic        clock_i,
  input  wire logic        valid_i,
  input  wire logic        first_i,
  input  wire logic        last_i,
  input  wire logic [31:0] quad_i,
  input  wire logic [27:0] side_i,
  output logic             ready_o
);
  logic [31:0] beats[$];
  logic [27:0] sides[$];
  int          lasts = 0;

  // A beat is taken only on an edge where valid and ready meet.
  always @(posedge clock_i) begin
    if (valid_i && ready_o) begin
      beats.push_back(quad_i);
      if (first_i) sides.push_back(side_i);
      if (last_i) lasts++;
    end
    ready_o <= 1'($urandom_range(0, 1));
  end

  // The sink starts out stalled.
  initial ready_o = 1'b0;
endmodule

// File: tb/serial_link_framer_bench.sv
`timescale 1ns/1ps

// Self-checking bench: receive formatting, isochronous transmit and registers.
module serial_link_framer_bench import link_fmt_pkg::*;;
  logic clock = 0, reset = 1, rd = 0, wr = 0, wreq, rs = 0, bv = 0, re = 0, cs = 0, ready;
  logic [4:0] addr = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic [9:0] bs = 0;
  logic [5:0] nd = 0, lb = 0;
  logic [1:0] rt = 0, sp = 0;
  logic [3:0] tc = 0, ak = 0, pr = 0;
  logic [15:0] src = 0, ln = 0, xt = 0;
  logic [47:0] off = 0;
  logic [7:0] byt = 0;
  logic iv, ifst, ilst;
  logic [31:0] iq;
  logic [1:0] isp;
  logic [5:0] ich;
  logic [3:0] isy;
  logic [15:0] iln;
  int err_count = 0, comparisons = 0;

  serial_link_framer #(.RX_AW(6), .TX_AW(4)) u_dut (.clock_i(clock), .reset_i(reset), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .rx_start_i(rs), .rx_dest_bus_i(bs),
    .rx_dest_node_i(nd), .rx_label_i(lb), .rx_retry_i(rt), .rx_tcode_i(tc), .rx_priority_i(pr),
    .rx_source_id_i(src), .rx_offset_i(off), .rx_length_i(ln), .rx_ext_tcode_i(xt), .rx_speed_i(sp),
    .rx_byte_valid_i(bv), .rx_byte_i(byt), .rx_end_i(re), .returned_ack_code_i(ak), .cycle_start_i(cs),
    .iso_ready_i(ready), .iso_valid_o(iv), .iso_first_o(ifst), .iso_last_o(ilst), .iso_quad_o(iq),
    .iso_speed_o(isp), .iso_chan_o(ich), .iso_sy_o(isy), .iso_len_o(iln));
  iso_sink u_sink (.clock_i(clock), .valid_i(iv), .first_i(ifst), .quad_i(iq), .side_i({iln, ich, isp, isy}),
    .last_i(ilst), .ready_o(ready));

  // The clock toggles every 12.5 ns, half of its 25 ns period.
  always #12.5 clock = ~clock;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low at an edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clock);
    end while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, e, q);
  endtask

  function automatic logic [31:0] iso_hdr(input logic [15:0] l, input logic [1:0] t, input logic [5:0] c,
                                          input logic [1:0] s, input logic [3:0] y);
    return {l, t, c, 2'b00, s, y};
  endfunction

  // Drives one received block packet and checks every quadlet the host reads back.
  task automatic rx_pkt(input logic [3:0] t, input logic [1:0] r, input int nb, input logic [3:0] p,
                        input logic [47:0] o);
    logic [31:0] e[$];
    logic [31:0] d;
    logic [15:0] l;
    logic [7:0] v;
    logic [53:0] h;
    logic [1:0] s;
    logic [3:0] a;
    @(posedge clock);
    l = (t == TCODE_WR_RESP) ? 16'($urandom) : 16'(nb);
    h = 54'({$urandom, $urandom});
    s = 2'($urandom_range(0, 2));
    a = 4'($urandom);
    {bs, nd, lb, src, xt} <= h;
    sp <= s;
    ak <= a;
    pr <= p;
    e.push_back({h[53:32], r, t, p});
    e.push_back({h[31:16], (t == TCODE_LOCK_RESP) ? {o[47:44], 12'h000} : o[47:32]});
    e.push_back(o[31:0]);
    e.push_back({(t == TCODE_WR_RESP) ? 16'h0000 : l, h[15:0]});
    rs <= 1'b1;
    rt <= r;
    tc <= t;
    off <= o;
    ln <= l;
    d = 32'h0;
    for (int k = 0; k < nb; k++) begin
      v = 8'($urandom);
      d[31 - 8 * (k % 4) -: 8] = v;
      if (k % 4 == 3 || k == nb - 1) e.push_back(d);
      if (k % 4 == 3) d = 32'h0;
      @(posedge clock);
      rs <= 1'b0;
      bv <= 1'b1;
      byt <= v;
    end
    e.push_back({14'h0, s, 12'h000, a});
    @(posedge clock);
    rs <= 1'b0;
    bv <= 1'b0;
    re <= 1'b1;
    @(posedge clock);
    re <= 1'b0;
    repeat (12) @(posedge clock);
    rdc(REG_RX_LEVEL, e.size(), "rx level");
    foreach (e[i]) rdc(REG_RX_DATA, e[i], "rx quadlet");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Stops a hung run well past the expected length of the tests.
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    logic [31:0] ha, pa0, pa1, hc;
    logic [31:0] ex [4];
    logic [27:0] sa;
    int n;
    void'($urandom(32'hD21B));
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rdc(REG_CTRL, 32'h0, "ctrl reset");
    rdc(REG_STATUS, 32'h0, "status reset");
    rdc(5'h18, 32'h0, "unmapped");
    rdc(REG_TX_SPACE, 32'h10, "tx space");
    $display("test reset done");
    bus(1'b1, REG_CTRL, 32'h3);
    for (int i = 0; i < 4; i++)
      rx_pkt((i == 1) ? TCODE_LOCK_RESP : (i == 2) ? TCODE_WR_RESP : 4'h1, 2'(i),
             (i == 2) ? 0 : (i == 0) ? 6 : 4 + i, (i == 3) ? 4'h3 : 4'h0,
             {$urandom, $urandom} & 48'hFFFF_FFFF_FFFC | ((i == 3) ? 48'h2 : 48'h0));
    rdc(REG_STATUS, (32'h1 << ST_ALIGN) | (32'h1 << ST_PRIO), "align and priority flags");
    bus(1'b1, REG_STATUS, 32'h1F);
    rdc(REG_STATUS, 32'h0, "status cleared");
    $display("test receive done");
    sa = {16'h0006, 6'($urandom), 2'($urandom_range(0, 2)), 4'($urandom)};
    ha = iso_hdr(16'h0006, ISO_TAG_FORMATTED, sa[11:6], sa[5:4], sa[3:0]);
    pa0 = $urandom;
    pa1 = $urandom & 32'hFFFF0000;
    hc = iso_hdr(16'h0000, ISO_TAG_FORMATTED, 6'h3F, 2'h2, 4'hA);
    ex = '{ha, pa0, pa1, hc};
    bus(1'b1, REG_TX_DATA, ha);
    bus(1'b1, REG_TX_DATA, pa0);
    bus(1'b1, REG_TX_DATA, pa1);
    bus(1'b1, REG_TX_DATA, iso_hdr(16'h0004, 2'h1, 6'h1, 2'h0, 4'h0));
    bus(1'b1, REG_TX_DATA, $urandom);
    bus(1'b1, REG_TX_DATA, hc);
    repeat (10) @(posedge clock);
    chk("idle beats", 0, u_sink.beats.size());
    cs <= 1'b1;
    @(posedge clock);
    cs <= 1'b0;
    n = 0;
    while (u_sink.beats.size() < 4 && n < 300) begin
      @(posedge clock);
      n++;
    end
    chk("beat count", 4, u_sink.beats.size());
    chk("last count", 2, u_sink.lasts);
    foreach (ex[i]) chk("iso beat", ex[i], u_sink.beats[i]);
    chk("side a", sa, u_sink.sides[0]);
    chk("side c", {16'h0, 6'h3F, 2'h2, 4'hA}, u_sink.sides[1]);
    rdc(REG_STATUS, 32'h1 << ST_TAG, "tag flag");
    $display("test transmit done");
    wrap_up();
  end
endmodule
